// *** fld_pkg.sv ***
// Constants and carrier types for the LED fault flag logic.
package fld_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 100;
   localparam int DEGLITCH_NS     = 10000;
   localparam int MASK_NS         = 130000;
   localparam int HICCUP_NS       = 1000000;
   localparam int REG_SW_CYCLES   = 256;
   // Least times round up, the retry period rounds down.
   localparam int DEGLITCH_CYC    = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MASK_CYC        = (MASK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HICCUP_CYC      = HICCUP_NS / CLK_PERIOD_NS;
   localparam int TIMER_W         = 16;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int          ADDR_W        = 8;
   localparam int          DATA_W        = 32;
   localparam logic [7:0]  ADDR_STATUS   = 8'h00;
   localparam logic [7:0]  ADDR_EVENT    = 8'h04;
   localparam logic [7:0]  ADDR_IRQ_MASK = 8'h08;
   localparam int          EV_W          = 4;
   localparam logic [3:0]  IRQ_MASK_RST  = 4'h0;
   localparam int          EV_ASSERT     = 0;
   localparam int          EV_RELEASE    = 1;
   localparam int          EV_HICCUP     = 2;
   localparam int          EV_REGULATED  = 3;
   localparam int          ST_FLAG       = 0;
   localparam int          ST_HICCUP     = 1;
   localparam int          ST_REGULATED  = 2;
   localparam int          ST_GATE       = 3;
   localparam int          ST_MASKING    = 4;
   localparam int          ST_W          = 5;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic maskCmpHigh;   // open_mask_threshold_input above mask_reference_level
      logic adimHigh;      // analog_dim_input above 264 mV
      logic openCond;      // sensed_regulation_voltage below 25 % at max duty
      logic shortCond;     // output below 1.5 V
      logic dimGate;       // dimming gate input
      logic swCycle;       // toggles once per switching cycle
   } fld_pins_type;

   localparam int PINS_W = $bits(fld_pins_type);

   typedef enum logic [0:0] {
      HIC_IDLE,
      HIC_RETRY
   } fld_hic_type;

endpackage

// *** fld_sync.sv ***
// Two flip-flop synchroniser for a bundle of asynchronous levels.
`timescale 1ns/1ps
module fld_sync
   import fld_pkg::*;
#(
   parameter int W = 1
)(
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] asyncIn,
   output logic      [W-1:0] syncOut
);

   // ----------------------------------------------------------------
   // One synchroniser per bit
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : gBit
         logic meta_q;
         logic meta_d;
         logic sync_q;
         logic sync_d;
         always_comb begin
            meta_d = asyncIn[i];
            sync_d = meta_q;
         end
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
            end else begin
               meta_q <= meta_d;
               sync_q <= sync_d;
            end
         end
         assign syncOut[i] = sync_q;
      end
   endgenerate

endmodule

// *** fld_timer.sv ***
// Loadable down counter; done is high while the count stands at zero.
`timescale 1ns/1ps
module fld_timer
   import fld_pkg::*;
#(
   parameter int               W         = TIMER_W,
   parameter logic [W-1:0]     RESET_VAL = '0
)(
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         load,
   input  wire logic [W-1:0] loadValue,
   input  wire logic         en,
   output logic              done
);

   logic [W-1:0] count_q;
   logic [W-1:0] count_d;

   // ----------------------------------------------------------------
   // Next count
   // ----------------------------------------------------------------
   always_comb begin
      count_d = count_q;
      if (load) begin
         count_d = loadValue;
      end else if (en && count_q != '0) begin
         count_d = count_q - W'(1);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_q <= RESET_VAL;
      end else begin
         count_q <= count_d;
      end
   end

   assign done = (count_q == '0);

endmodule

// *** fld_fault_flag.sv ***
// Open-LED and output-short fault supervision with latched active-low flag.
//
// Contract
// - Open detection is masked while the mask comparator or the dimming comparator is low.
// - While masked, an asserted flag stays asserted as long as the open condition lasts.
// - Open is detected only with both comparators high and regulation voltage low at max duty.
// - A qualified open fault asserts the flag and starts hiccup, flag held through all periods.
// - After the open clears, the flag is released only at period end with the gate high.
// - Comparator levels arrive as high or low and select which faults are qualified.
// - An output short with dimming above 264 mV asserts the flag without hiccup.
// - When the short disappears, operation resumes with no restart sequence.
// - A fault is flagged only after being present for the whole deglitch time.
// - Each rising edge of the dimming gate starts a mask time with no detection.
// - A gate pulse shorter than the mask time never detects a fault.
// - On the gate falling edge the flag is latched and held while the gate is low.
// - Deglitch and mask times are fixed constants with no configuration input.
// - Hiccup retries about every 1 ms until the fault clears.
// - After a fault is removed, 256 switching cycles pass before regulation is reported.
`timescale 1ns/1ps
module fld_fault_flag
   import fld_pkg::*;
#(
   parameter int HICCUP_CYCLES = HICCUP_CYC
)(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire fld_pins_type      pins,
   input  wire logic [ADDR_W-1:0] regAddr,
   input  wire logic [DATA_W-1:0] regWdata,
   input  wire logic              regWr,
   input  wire logic              regRd,
   output logic      [DATA_W-1:0] regRdata,
   output logic                   irq,
   output logic                   faultFlagN,
   output logic                   hiccupReq,
   output logic                   inRegulation
);

   // ----------------------------------------------------------------
   // Input synchronisation and edges
   // ----------------------------------------------------------------
   fld_pins_type s;
   logic [PINS_W-1:0] syncBits;
   logic              gatePrev_q;
   logic              gatePrev_d;
   logic              swPrev_q;
   logic              swPrev_d;
   logic              shortPrev_q;
   logic              shortPrev_d;

   fld_sync #(
      .W (PINS_W)
   ) uSync (
      .clk     (clk),
      .rst     (rst),
      .asyncIn (pins),
      .syncOut (syncBits)
   );

   assign s = fld_pins_type'(syncBits);

   always_comb begin
      gatePrev_d  = s.dimGate;
      swPrev_d    = s.swCycle;
      shortPrev_d = s.shortCond;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gatePrev_q  <= 1'b0;
         swPrev_q    <= 1'b0;
         shortPrev_q <= 1'b0;
      end else begin
         gatePrev_q  <= gatePrev_d;
         swPrev_q    <= swPrev_d;
         shortPrev_q <= shortPrev_d;
      end
   end

   logic gateRise;
   logic swTick;
   logic shortGone;

   assign gateRise  = s.dimGate & ~gatePrev_q;
   assign swTick    = s.swCycle ^ swPrev_q;
   assign shortGone = shortPrev_q & ~s.shortCond;

   // ----------------------------------------------------------------
   // Mask window after each gate rising edge
   // ----------------------------------------------------------------
   logic maskDone;
   logic detectWin;

   // The window length is a package constant; no port can alter it.
   fld_timer #(
      .W         (TIMER_W),
      .RESET_VAL ('0)
   ) uMask (
      .clk       (clk),
      .rst       (rst),
      .load      (gateRise),
      .loadValue (TIMER_W'(MASK_CYC)),
      .en        (1'b1),
      .done      (maskDone)
   );

   // Detection needs the gate high and the mask expired, so a short
   // gate pulse never reaches a detection.
   assign detectWin = s.dimGate & maskDone & ~gateRise;

   // ----------------------------------------------------------------
   // Qualification and deglitch
   // ----------------------------------------------------------------
   logic openEnable;
   logic openPresent;
   logic shortPresent;
   logic openDegDone;
   logic shortDegDone;
   logic openHit;
   logic shortHit;

   // The comparators deliver levels: high above threshold, low below.
   assign openEnable   = s.maskCmpHigh & s.adimHigh;
   assign openPresent  = openEnable & s.openCond & detectWin;
   assign shortPresent = s.adimHigh & s.shortCond & detectWin;

   // Any gap in the condition reloads the count, so only an
   // uninterrupted fault for the full deglitch time gets through.
   fld_timer #(
      .W         (TIMER_W),
      .RESET_VAL (TIMER_W'(DEGLITCH_CYC))
   ) uOpenDeg (
      .clk       (clk),
      .rst       (rst),
      .load      (~openPresent),
      .loadValue (TIMER_W'(DEGLITCH_CYC)),
      .en        (1'b1),
      .done      (openDegDone)
   );

   fld_timer #(
      .W         (TIMER_W),
      .RESET_VAL (TIMER_W'(DEGLITCH_CYC))
   ) uShortDeg (
      .clk       (clk),
      .rst       (rst),
      .load      (~shortPresent),
      .loadValue (TIMER_W'(DEGLITCH_CYC)),
      .en        (1'b1),
      .done      (shortDegDone)
   );

   assign openHit  = openPresent & openDegDone;
   assign shortHit = shortPresent & shortDegDone;

   // ----------------------------------------------------------------
   // Hiccup retry
   // ----------------------------------------------------------------
   fld_hic_type hic_q;
   fld_hic_type hic_d;
   logic        hicLoad;
   logic        hicDone;
   logic        hicEnd;

   fld_timer #(
      .W         (TIMER_W),
      .RESET_VAL ('0)
   ) uHiccup (
      .clk       (clk),
      .rst       (rst),
      .load      (hicLoad),
      .loadValue (TIMER_W'(HICCUP_CYCLES)),
      .en        (1'b1),
      .done      (hicDone)
   );

   always_comb begin
      hic_d   = hic_q;
      hicLoad = 1'b0;
      hicEnd  = 1'b0;
      case (hic_q)
         HIC_IDLE: begin
            if (openHit) begin
               hic_d   = HIC_RETRY;
               hicLoad = 1'b1;
            end
         end
         HIC_RETRY: begin
            if (hicDone) begin
               if (s.openCond) begin
                  hicLoad = 1'b1;
               end else begin
                  hic_d  = HIC_IDLE;
                  hicEnd = 1'b1;
               end
            end
         end
         default: begin
            hic_d = HIC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hic_q <= HIC_IDLE;
      end else begin
         hic_q <= hic_d;
      end
   end

   assign hiccupReq = (hic_q == HIC_RETRY);

   // ----------------------------------------------------------------
   // Fault flag
   // ----------------------------------------------------------------
   logic fault_q;
   logic fault_d;
   logic keepFault;

   always_comb begin
      // Hiccup holds the flag for every remaining period; release can
      // only come after the period ends and with the gate high.
      keepFault = hiccupReq
                | (fault_q & ~openEnable & s.openCond)
                | (fault_q & s.adimHigh & s.shortCond);
      if (s.dimGate) begin
         fault_d = openHit | shortHit | keepFault;
      end else begin
         fault_d = fault_q;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fault_q <= 1'b0;
      end else begin
         fault_q <= fault_d;
      end
   end

   assign faultFlagN = ~fault_q;

   // ----------------------------------------------------------------
   // Current-to-regulation count
   // ----------------------------------------------------------------
   logic regLoad;

   // A short never stops switching, so its removal only restarts this
   // count and nothing else.
   assign regLoad = hicEnd | shortGone;

   fld_timer #(
      .W         (TIMER_W),
      .RESET_VAL ('0)
   ) uRegulate (
      .clk       (clk),
      .rst       (rst),
      .load      (regLoad),
      .loadValue (TIMER_W'(REG_SW_CYCLES)),
      .en        (swTick),
      .done      (inRegulation)
   );

   logic regPrev_q;
   logic regPrev_d;
   logic faultPrev_q;
   logic faultPrev_d;

   assign regPrev_d   = inRegulation;
   assign faultPrev_d = fault_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         regPrev_q   <= 1'b1;
         faultPrev_q <= 1'b0;
      end else begin
         regPrev_q   <= regPrev_d;
         faultPrev_q <= faultPrev_d;
      end
   end

   // ----------------------------------------------------------------
   // Event status, mask and interrupt
   // ----------------------------------------------------------------
   logic [EV_W-1:0] event_q;
   logic [EV_W-1:0] event_d;
   logic [EV_W-1:0] irqMask_q;
   logic [EV_W-1:0] irqMask_d;
   logic [EV_W-1:0] evSet;
   logic [EV_W-1:0] evClr;

   always_comb begin
      evSet               = '0;
      evSet[EV_ASSERT]    = fault_q & ~faultPrev_q;
      evSet[EV_RELEASE]   = ~fault_q & faultPrev_q;
      evSet[EV_HICCUP]    = hicLoad & (hic_q == HIC_IDLE);
      evSet[EV_REGULATED] = inRegulation & ~regPrev_q;
      evClr = (regWr && regAddr == ADDR_EVENT) ? regWdata[EV_W-1:0] : '0;
      // A new event wins over a clear in the same cycle.
      event_d   = (event_q & ~evClr) | evSet;
      irqMask_d = irqMask_q;
      if (regWr && regAddr == ADDR_IRQ_MASK) begin
         irqMask_d = regWdata[EV_W-1:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         event_q   <= '0;
         irqMask_q <= IRQ_MASK_RST;
      end else begin
         event_q   <= event_d;
         irqMask_q <= irqMask_d;
      end
   end

   assign irq = |(event_q & irqMask_q);

   // ----------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic [ST_W-1:0]   status;

   always_comb begin
      status               = '0;
      status[ST_FLAG]      = fault_q;
      status[ST_HICCUP]    = hiccupReq;
      status[ST_REGULATED] = inRegulation;
      status[ST_GATE]      = s.dimGate;
      status[ST_MASKING]   = ~maskDone;
      rdata_d = '0;
      if (regRd) begin
         case (regAddr)
            ADDR_STATUS:   rdata_d = DATA_W'(status);
            ADDR_EVENT:    rdata_d = DATA_W'(event_q);
            ADDR_IRQ_MASK: rdata_d = DATA_W'(irqMask_q);
            default:       rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign regRdata = rdata_q;

endmodule

// *** fld_fault_flag_properties.sv ***
// Concurrent checks on the ports of the LED fault flag logic.
`timescale 1ns/1ps
module fld_fault_flag_properties
   import fld_pkg::*;
#(
   parameter int HICCUP_CYCLES = HICCUP_CYC
)(
   input wire logic         clk,
   input wire logic         rst,
   input wire fld_pins_type pins,
   input wire logic         faultFlagN,
   input wire logic         hiccupReq,
   input wire logic         inRegulation
);
   // ------------------------------------------------------------
   // Helper counters
   // ------------------------------------------------------------
   // Raw pins lead the synchronised view, so the bounds keep some slack.
   logic sc;
   logic oc;
   logic gateQ;
   logic swQ;
   int   riseCnt;
   int   lowCnt;
   int   openCnt;
   int   shortCnt;
   int   condCnt;
   int   togCnt;
   int   hicCnt;
   assign sc = pins.shortCond && pins.adimHigh;
   assign oc = pins.openCond && pins.adimHigh && pins.maskCmpHigh;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gateQ    <= 1'b0;
         swQ      <= 1'b0;
         riseCnt  <= 0;
         lowCnt   <= 0;
         openCnt  <= 0;
         shortCnt <= 0;
         condCnt  <= 0;
         togCnt   <= 0;
         hicCnt   <= 0;
      end else begin
         gateQ    <= pins.dimGate;
         swQ      <= pins.swCycle;
         riseCnt  <= (pins.dimGate && !gateQ) ? 0 : riseCnt + 1;
         lowCnt   <= pins.dimGate ? 0 : lowCnt + 1;
         openCnt  <= oc ? openCnt + 1 : 0;
         shortCnt <= sc ? shortCnt + 1 : 0;
         condCnt  <= (oc || sc) ? condCnt + 1 : 0;
         togCnt   <= inRegulation ? 0 : togCnt + int'(pins.swCycle != swQ);
         hicCnt   <= hiccupReq ? hicCnt + 1 : 0;
      end
   end
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence s_hicOn;
      hiccupReq [*2];
   endsequence
   property p_reset;
      $fell(rst) |-> faultFlagN && !hiccupReq && inRegulation;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs wrong after reset");
   property p_mask;
      $fell(faultFlagN) |-> riseCnt >= MASK_CYC + DEGLITCH_CYC;
   endproperty
   a_mask: assert property (p_mask) else $error("flag fell inside mask");
   property p_deglitch;
      $fell(faultFlagN) |-> condCnt >= DEGLITCH_CYC;
   endproperty
   a_deglitch: assert property (p_deglitch) else $error("flag fell early");
   property p_freeze;
      lowCnt >= 4 |-> $stable(faultFlagN);
   endproperty
   a_freeze: assert property (p_freeze) else $error("flag moved, gate low");
   property p_release;
      $rose(faultFlagN) |-> !hiccupReq && ($past(pins.dimGate, 2) || $past(pins.dimGate, 3));
   endproperty
   a_release: assert property (p_release) else $error("bad flag release");
   property p_short_hold;
      !faultFlagN && shortCnt >= 4 |=> !faultFlagN;
   endproperty
   a_short_hold: assert property (p_short_hold) else $error("short flag lost");
   property p_hic_cause;
      $rose(hiccupReq) |-> openCnt >= DEGLITCH_CYC;
   endproperty
   a_hic_cause: assert property (p_hic_cause) else $error("hiccup without open");
   property p_hic_flag;
      s_hicOn |-> !faultFlagN;
   endproperty
   a_hic_flag: assert property (p_hic_flag) else $error("flag high in hiccup");
   property p_hic_len;
      $fell(hiccupReq) |-> hicCnt >= HICCUP_CYCLES - 1;
   endproperty
   a_hic_len: assert property (p_hic_len) else $error("hiccup too short");
   property p_regulated;
      $rose(inRegulation) |-> togCnt >= 255;
   endproperty
   a_regulated: assert property (p_regulated) else $error("regulation too soon");
endmodule

// *** fld_board_model.sv ***
// Board-side model: sets the mask threshold level and watches the fault flag.
`timescale 1ns/1ps
module fld_board_model (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic tieToSupply,
   input  wire logic faultFlagN,
   output logic      maskCmpHigh,
   output int        flagCount
);
   // The threshold pin is always strapped to a rail, never left floating.
   assign maskCmpHigh = tieToSupply;
   logic flagQ;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flagQ     <= 1'b1;
         flagCount <= 0;
      end else begin
         flagQ <= faultFlagN;
         if (flagQ && !faultFlagN) begin
            flagCount <= flagCount + 1;
         end
      end
   end
endmodule

// *** fld_fault_flag_tb.sv ***
// Self-checking testbench for the LED fault flag logic.
`timescale 1ns/1ps
module fld_fault_flag_tb;
   import fld_pkg::*;
   // ------------------------------------------------------------
   // Signals and instances
   // ------------------------------------------------------------
   localparam int HICCUP_CYCLES = 200;
   logic              clk      = 1'b0;
   logic              rst      = 1'b1;
   logic              tieHigh  = 1'b1;
   fld_pins_type      drv      = '0;
   logic              swDrv    = 1'b0;
   fld_pins_type      pins;
   logic              maskLvl;
   logic [ADDR_W-1:0] regAddr  = '0;
   logic [DATA_W-1:0] regWdata = '0;
   logic              regWr    = 1'b0;
   logic              regRd    = 1'b0;
   logic [DATA_W-1:0] regRdata;
   logic [DATA_W-1:0] rdv;
   logic              irq;
   logic              faultFlagN;
   logic              hiccupReq;
   logic              inRegulation;
   int                flagCount;
   int                num_errors   = 0;
   int                total_checks = 0;
   int                cycles       = 0;
   int                expFlags     = 0;
   int                n;
   always #50 clk = ~clk;
   always_comb begin
      pins = drv;
      pins.maskCmpHigh = maskLvl;
      pins.swCycle = swDrv;
   end
   fld_fault_flag #(.HICCUP_CYCLES(HICCUP_CYCLES)) i_fld_fault_flag (
      .clk(clk), .rst(rst), .pins(pins), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq),
      .faultFlagN(faultFlagN), .hiccupReq(hiccupReq), .inRegulation(inRegulation));
   fld_board_model i_fld_board_model (
      .clk(clk), .rst(rst), .tieToSupply(tieHigh), .faultFlagN(faultFlagN),
      .maskCmpHigh(maskLvl), .flagCount(flagCount));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chkb(input string what, input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
      end
   endtask
   task automatic chkw(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      regAddr  <= a;
      regWdata <= d;
      regWr    <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge clk);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 rdv = regRdata;
   endtask
   task automatic waitFlag(input logic exp, input int lim);
      n = 0;
      while (faultFlagN !== exp && n < lim) begin
         @(posedge clk);
         n++;
      end
      #1 chkb("faultFlagN", exp, faultFlagN);
   endtask
   task automatic wrap_up();
      $display("checks %0d, errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Switching cycles tick steadily; a hang is cut off well past the planned run.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles % 4 == 0) begin
         swDrv <= ~swDrv;
      end
      if (cycles == 30000) begin
         num_errors++;
         wrap_up();
      end
   end
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      n = $urandom(32'h0000_80ec);
      cyc(8);
      rst <= 1'b0;
      cyc(1);
      #1 chkb("faultFlagN", 1'b1, faultFlagN);
      chkb("hiccupReq", 1'b0, hiccupReq);
      chkb("inRegulation", 1'b1, inRegulation);
      rd(ADDR_IRQ_MASK);
      chkw("irqMask", 32'h0000_0000, rdv);
      rd(8'h0C);
      chkw("unmapped", 32'h0000_0000, rdv);
      drv.adimHigh  <= 1'b1;
      drv.shortCond <= 1'b1;
      drv.dimGate   <= 1'b1;
      cyc(1395);
      #1 chkb("faultFlagN", 1'b1, faultFlagN);
      waitFlag(1'b0, 30);
      expFlags++;
      chkb("hiccupReq", 1'b0, hiccupReq);
      chkb("irq", 1'b0, irq);
      rd(ADDR_EVENT);
      chkw("event", 32'h0000_0001, rdv);
      wr(ADDR_IRQ_MASK, 32'h0000_0001);
      cyc(2);
      #1 chkb("irq", 1'b1, irq);
      wr(ADDR_EVENT, 32'h0000_000F);
      cyc(2);
      #1 chkb("irq", 1'b0, irq);
      rd(ADDR_EVENT);
      chkw("eventCleared", 32'h0000_0000, rdv);
      drv.dimGate <= 1'b0;
      cyc(5);
      drv.shortCond <= 1'b0;
      n = cycles;
      cyc(60);
      #1 chkb("faultFlagN", 1'b0, faultFlagN);
      chkb("inRegulation", 1'b0, inRegulation);
      drv.dimGate <= 1'b1;
      while (inRegulation !== 1'b1 && cycles - n < 1200) @(posedge clk);
      n = cycles - n;
      chkb("regulationDelay", 1'b1, inRegulation && n >= 1020 && n <= 1032);
      waitFlag(1'b1, 1500);
      cyc(1400);
      drv.shortCond <= 1'b1;
      cyc(20 + $urandom % 70);
      drv.shortCond <= 1'b0;
      cyc(150);
      #1 chkb("faultFlagN", 1'b1, faultFlagN);
      drv.dimGate   <= 1'b0;
      drv.shortCond <= 1'b1;
      cyc(10);
      drv.dimGate <= 1'b1;
      cyc(1200);
      drv.dimGate <= 1'b0;
      cyc(300);
      #1 chkb("faultFlagN", 1'b1, faultFlagN);
      drv.shortCond <= 1'b0;
      tieHigh       <= 1'b0;
      drv.openCond  <= 1'b1;
      drv.dimGate   <= 1'b1;
      cyc(1600);
      #1 chkb("faultFlagN", 1'b1, faultFlagN);
      tieHigh      <= 1'b1;
      drv.adimHigh <= 1'b0;
      cyc(300);
      #1 chkb("faultFlagN", 1'b1, faultFlagN);
      drv.adimHigh <= 1'b1;
      waitFlag(1'b0, 150);
      expFlags++;
      cyc(2);
      #1 chkb("hiccupReq", 1'b1, hiccupReq);
      rd(ADDR_STATUS);
      chkw("status", 32'h0000_000B, rdv & 32'h0000_000B);
      tieHigh <= 1'b0;
      cyc(HICCUP_CYCLES * 2);
      #1 chkb("faultFlagN", 1'b0, faultFlagN);
      chkb("hiccupReq", 1'b1, hiccupReq);
      drv.openCond <= 1'b0;
      tieHigh      <= 1'b1;
      waitFlag(1'b1, HICCUP_CYCLES + 20);
      chkb("hiccupReq", 1'b0, hiccupReq);
      chkw("flagCount", 32'(expFlags), 32'(flagCount));
      wrap_up();
   end
endmodule

bind fld_fault_flag fld_fault_flag_properties #(
   .HICCUP_CYCLES(HICCUP_CYCLES)
) i_fld_fault_flag_properties (
   .clk          (clk),
   .rst          (rst),
   .pins         (pins),
   .faultFlagN   (faultFlagN),
   .hiccupReq    (hiccupReq),
   .inRegulation (inRegulation)
);
